//--- logic/reset_init_pkg.sv
/*
 * constants for the register reset and wake-up initialisation block:
 * register indices, reset values, implemented-bit masks and vectors.
 * assumes the core drives one-cycle reset-class and wake-up events on clk_sys.
 */
// Overview of operation
// - interrupt wake with a global enable set jumps to vector 0008h or 0018h
// - that wake pushes the current program counter and advances the stack pointer
// - a wake-up sets only the interrupt control and flag bits that caused it
// - port bit 6 works only in the two io oscillator modes, else reads 0
// - bus controller status resets alike in all five mirrored views
// - timer zero control loads ff on every reset, kept on wake-up
// - timer two period loads ff on every reset and every wake-up
// - low voltage detect control loads 05 on resets, kept on wake-up
// - timer two control clears its seven bits on resets, kept on wake-up
// - timer one control clears only on power-on or brown-out, bit 6 unused
// - serial address, status and both controls clear on resets, kept on wake
// - reset cause loads 01 11q0, 01 qquu or uu qquu per event class
// - counters, pointer low bytes and serial buffer undefined only after power-on
// - five-bit arithmetic status undefined after power-on, else kept
// - oscillator select and watchdog enable bits clear on resets, kept on wake
// - other resets load program counter 0000h, wake-up without vectoring resumes at pc plus two
package reset_init_pkg;
    localparam logic [20:0] PC_RESET = 21'h000000;
    localparam logic [20:0] VEC_HIGH = 21'h000008;
    localparam logic [20:0] VEC_LOW = 21'h000018;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] LVD_INIT = 8'h05;
    localparam logic [7:0] CAN_INIT = 8'h80;
    localparam logic [7:0] M_TONE = 8'hBF;
    localparam logic [7:0] M_TTWO = 8'h7F;
    localparam logic [7:0] M_SIX = 8'h3F;
    localparam logic [7:0] M_FIVE = 8'h1F;
    localparam logic [7:0] M_NIB = 8'h0F;
    localparam logic [7:0] M_BIT = 8'h01;
    localparam logic [7:0] RC_POR = 8'h1C;
    localparam logic [7:0] RC_POR_Q = 8'h02;
    localparam logic [7:0] RC_RST = 8'h10;
    localparam logic [7:0] RC_Q = 8'h0C;
    localparam logic [7:0] RC_KEEP_RST = 8'h03;
    localparam logic [7:0] RC_KEEP_WAKE = 8'h33;
    localparam int IO_BIT = 6;
    localparam logic [7:0] A_TZ_CTL = 8'h00, A_TZ_HI = 8'h01, A_TZ_LO = 8'h02, A_OSC = 8'h03;
    localparam logic [7:0] A_LVD = 8'h04, A_WD = 8'h05, A_CAUSE = 8'h06, A_TO_CTL = 8'h07;
    localparam logic [7:0] A_TO_HI = 8'h08, A_TO_LO = 8'h09, A_TT_CNT = 8'h0A, A_TT_PER = 8'h0B;
    localparam logic [7:0] A_TT_CTL = 8'h0C, A_SBUF = 8'h0D, A_SADDR = 8'h0E, A_SSTAT = 8'h0F;
    localparam logic [7:0] A_SCTL1 = 8'h10, A_SCTL2 = 8'h11, A_P1_UP = 8'h12, A_P1_LO = 8'h13;
    localparam logic [7:0] A_P2_UP = 8'h14, A_P2_LO = 8'h15, A_BANK = 8'h16, A_ALU = 8'h17;
    localparam logic [7:0] A_INTC = 8'h18, A_IFLAG = 8'h19, A_PINS = 8'h1A, A_LAT = 8'h1B;
    localparam logic [7:0] A_DIR = 8'h1C, A_SPTR = 8'h1D, A_CAN = 8'h1E, A_CAN_LAST = 8'h22;
    localparam logic [7:0] A_IND_FIRST = 8'h23, A_IND_LAST = 8'h27;
endpackage : reset_init_pkg

//--- logic/reset_init.sv
/*
 * register initialisation on power-on/brown-out, other resets and wake-up,
 * with program counter and return stack handling for interrupt wake-up.
 * assumes event inputs are one-cycle pulses from logic on clk_sys; only the
 * port pins come from outside and are synchronised here.
 */
// The register offsets and strobed register access are this design's own decisions.
module reset_init
    import reset_init_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    // reset and wake events
    input wire logic por_evt,
    input wire logic rst_evt,
    input wire logic wake_wdt_evt,
    input wire logic wake_int_evt,
    input wire logic int_high_prio,
    input wire logic high_priority_global_int_enable,
    input wire logic low_priority_global_int_enable,
    input wire logic [3:0] cause_q,
    input wire logic [7:0] wake_int_ctl_set,
    input wire logic [7:0] wake_flag_set,
    // core state
    input wire logic [20:0] pc_now,
    output logic [20:0] pc,
    output logic [4:0] stack_top_upper,
    output logic [7:0] stack_top_high,
    output logic [7:0] stack_top_low,
    output logic [4:0] return_stack_pointer,
    // first port and peripherals
    input wire logic osc_io_mode,
    input wire logic [7:0] first_port_pins,
    input wire logic [7:0] can_status_in,
    output logic [7:0] first_port_latch,
    output logic [7:0] first_port_direction
);
    typedef struct packed {
        logic [20:0] pc;
        logic [20:0] tos;
        logic [4:0] sptr;
        logic [7:0] tz_ctl, tz_hi, tz_lo, osc, lvd, wd, cause, to_ctl, to_hi, to_lo;
        logic [7:0] tt_cnt, tt_per, tt_ctl, sbuf, saddr, sstat, sctl1, sctl2;
        logic [7:0] p1_up, p1_lo, p2_up, p2_lo, bank, alu, intc, iflag, lat, dir;
        logic [7:0] pin_s1, pin_s2, can, rdata;
    } state_t;

    state_t state_r;
    state_t state_nxt;
    logic wake;
    logic vec_take;
    logic [7:0] rd_val;

    assign wake = (wake_wdt_evt || wake_int_evt) && !por_evt && !rst_evt;
    assign vec_take = wake_int_evt && (high_priority_global_int_enable || low_priority_global_int_enable);

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb
    begin
        rd_val = 8'h00;
        case (addr)
            A_TZ_CTL: rd_val = state_r.tz_ctl;
            A_TZ_HI: rd_val = state_r.tz_hi;
            A_TZ_LO: rd_val = state_r.tz_lo;
            A_OSC: rd_val = state_r.osc;
            A_LVD: rd_val = state_r.lvd;
            A_WD: rd_val = state_r.wd;
            A_CAUSE: rd_val = state_r.cause;
            A_TO_CTL: rd_val = state_r.to_ctl;
            A_TO_HI: rd_val = state_r.to_hi;
            A_TO_LO: rd_val = state_r.to_lo;
            A_TT_CNT: rd_val = state_r.tt_cnt;
            A_TT_PER: rd_val = state_r.tt_per;
            A_TT_CTL: rd_val = state_r.tt_ctl;
            A_SBUF: rd_val = state_r.sbuf;
            A_SADDR: rd_val = state_r.saddr;
            A_SSTAT: rd_val = state_r.sstat;
            A_SCTL1: rd_val = state_r.sctl1;
            A_SCTL2: rd_val = state_r.sctl2;
            A_P1_UP: rd_val = state_r.p1_up;
            A_P1_LO: rd_val = state_r.p1_lo;
            A_P2_UP: rd_val = state_r.p2_up;
            A_P2_LO: rd_val = state_r.p2_lo;
            A_BANK: rd_val = state_r.bank;
            A_ALU: rd_val = state_r.alu;
            A_INTC: rd_val = state_r.intc;
            A_IFLAG: rd_val = state_r.iflag;
            A_PINS: rd_val = osc_io_mode ? state_r.pin_s2 : (state_r.pin_s2 & ~(8'h01 << IO_BIT));
            A_LAT: rd_val = state_r.lat;
            A_DIR: rd_val = state_r.dir;
            A_SPTR: rd_val = {3'b000, state_r.sptr};
            default:
            begin
                // all status views share one store
                if (addr >= A_CAN && addr <= A_CAN_LAST)
                    rd_val = state_r.can;
                else
                    rd_val = 8'h00;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.pin_s1 = first_port_pins;
        state_nxt.pin_s2 = state_r.pin_s1;
        state_nxt.can = can_status_in;
        state_nxt.rdata = rd_stb ? rd_val : 8'h00;
        if (wr_stb)
        begin
            // stores mask away unimplemented bits
            case (addr)
                A_TZ_CTL: state_nxt.tz_ctl = wr_data;
                A_TZ_HI: state_nxt.tz_hi = wr_data;
                A_TZ_LO: state_nxt.tz_lo = wr_data;
                A_OSC: state_nxt.osc = wr_data & M_BIT;
                A_LVD: state_nxt.lvd = wr_data & M_SIX;
                A_WD: state_nxt.wd = wr_data & M_BIT;
                A_CAUSE: state_nxt.cause = wr_data & M_SIX;
                A_TO_CTL: state_nxt.to_ctl = wr_data & M_TONE;
                A_TO_HI: state_nxt.to_hi = wr_data;
                A_TO_LO: state_nxt.to_lo = wr_data;
                A_TT_CNT: state_nxt.tt_cnt = wr_data;
                A_TT_PER: state_nxt.tt_per = wr_data;
                A_TT_CTL: state_nxt.tt_ctl = wr_data & M_TTWO;
                A_SBUF: state_nxt.sbuf = wr_data;
                A_SADDR: state_nxt.saddr = wr_data;
                A_SSTAT: state_nxt.sstat = wr_data;
                A_SCTL1: state_nxt.sctl1 = wr_data;
                A_SCTL2: state_nxt.sctl2 = wr_data;
                A_P1_UP: state_nxt.p1_up = wr_data & M_NIB;
                A_P1_LO: state_nxt.p1_lo = wr_data;
                A_P2_UP: state_nxt.p2_up = wr_data & M_NIB;
                A_P2_LO: state_nxt.p2_lo = wr_data;
                A_BANK: state_nxt.bank = wr_data & M_NIB;
                A_ALU: state_nxt.alu = wr_data & M_FIVE;
                A_INTC: state_nxt.intc = wr_data;
                A_IFLAG: state_nxt.iflag = wr_data;
                A_LAT: state_nxt.lat = wr_data;
                A_DIR: state_nxt.dir = wr_data;
                A_SPTR: state_nxt.sptr = wr_data[4:0];
                default: state_nxt.rdata = state_nxt.rdata;
            endcase
        end
        if (wake)
        begin
            // causing bits set even if software clears them this cycle
            state_nxt.intc = state_nxt.intc | wake_int_ctl_set;
            state_nxt.iflag = state_nxt.iflag | wake_flag_set;
            state_nxt.tt_per = ALL_ONES;
            state_nxt.cause = (state_r.cause & RC_KEEP_WAKE) | ({4'h0, cause_q} & RC_Q);
            if (vec_take)
            begin
                state_nxt.pc = int_high_prio ? VEC_HIGH : VEC_LOW;
                state_nxt.tos = pc_now;
                state_nxt.sptr = state_r.sptr + 5'd1;
            end
            else
                state_nxt.pc = pc_now + PC_STEP;
        end
        if (por_evt || rst_evt)
        begin
            state_nxt.pc = PC_RESET;
            state_nxt.tos = PC_RESET;
            state_nxt.sptr = 5'd0;
            state_nxt.tz_ctl = ALL_ONES;
            state_nxt.tt_per = ALL_ONES;
            state_nxt.lvd = LVD_INIT;
            state_nxt.tt_ctl = 8'h00;
            state_nxt.saddr = 8'h00;
            state_nxt.sstat = 8'h00;
            state_nxt.sctl1 = 8'h00;
            state_nxt.sctl2 = 8'h00;
            state_nxt.p1_up = 8'h00;
            state_nxt.p2_up = 8'h00;
            state_nxt.bank = 8'h00;
            state_nxt.osc = 8'h00;
            state_nxt.wd = 8'h00;
            state_nxt.intc = 8'h00;
            state_nxt.iflag = 8'h00;
            state_nxt.can = CAN_INIT;
            state_nxt.cause = RC_RST | ({4'h0, cause_q} & RC_Q) | (state_r.cause & RC_KEEP_RST);
        end
        if (por_evt)
        begin
            // undefined contents are simply cleared; nothing may rely on them
            state_nxt.to_ctl = 8'h00;
            state_nxt.tz_hi = 8'h00;
            state_nxt.tz_lo = 8'h00;
            state_nxt.to_hi = 8'h00;
            state_nxt.to_lo = 8'h00;
            state_nxt.tt_cnt = 8'h00;
            state_nxt.sbuf = 8'h00;
            state_nxt.p1_lo = 8'h00;
            state_nxt.p2_lo = 8'h00;
            state_nxt.alu = 8'h00;
            state_nxt.cause = RC_POR | ({4'h0, cause_q} & RC_POR_Q);
        end
        if (!osc_io_mode)
        begin
            state_nxt.lat[IO_BIT] = 1'b0;
            state_nxt.dir[IO_BIT] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= '0;
            state_r.tz_ctl <= ALL_ONES;
            state_r.tt_per <= ALL_ONES;
            state_r.lvd <= LVD_INIT;
            state_r.cause <= RC_POR;
            state_r.can <= CAN_INIT;
        end
        else
            state_r <= state_nxt;
    end

    assign rd_data = state_r.rdata;
    assign pc = state_r.pc;
    assign stack_top_upper = state_r.tos[20:16];
    assign stack_top_high = state_r.tos[15:8];
    assign stack_top_low = state_r.tos[7:0];
    assign return_stack_pointer = state_r.sptr;
    assign first_port_latch = state_r.lat;
    assign first_port_direction = state_r.dir;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    logic any_rst;
    assign any_rst = por_evt || rst_evt;

    AST_VECTOR: assert property (wake && vec_take |=> pc == ($past(int_high_prio) ? VEC_HIGH : VEC_LOW))
        else $error("interrupt wake vector wrong");
    AST_PUSH: assert property (wake && vec_take |=> return_stack_pointer == $past(return_stack_pointer) + 5'd1
        && {stack_top_upper, stack_top_high, stack_top_low} == $past(pc_now))
        else $error("wake push wrong");
    AST_WAKE_FLAGS: assert property (wake && !wr_stb |=>
        state_r.iflag == ($past(state_r.iflag) | $past(wake_flag_set)))
        else $error("wake flags wrong");
    AST_PORT_BIT: assert property (!osc_io_mode ##1 !osc_io_mode |->
        !first_port_latch[IO_BIT] && !first_port_direction[IO_BIT])
        else $error("port bit 6 live outside io mode");
    AST_PIN_VIEW: assert property (rd_stb && addr == A_PINS && !osc_io_mode |=> !rd_data[IO_BIT])
        else $error("port bit 6 read back outside io mode");
    AST_TZ_CTL: assert property (any_rst |=> state_r.tz_ctl == ALL_ONES)
        else $error("timer zero control not ff after reset");
    AST_TZ_KEEP: assert property (wake && !wr_stb |=> $stable(state_r.tz_ctl))
        else $error("timer zero control changed on wake");
    AST_PERIOD: assert property (any_rst || wake |=> state_r.tt_per == ALL_ONES)
        else $error("period not ff");
    AST_LVD_KEEP: assert property (wake && !wr_stb |=>
        $stable(state_r.lvd) && state_r.tt_ctl == $past(state_r.tt_ctl))
        else $error("wake disturbed control");
    AST_LVD_RESET: assert property (any_rst |=> state_r.lvd == LVD_INIT && state_r.tt_ctl == 8'h00)
        else $error("low voltage or timer two control not reset");
    AST_TONE: assert property (rst_evt && !por_evt && !wr_stb |=> $stable(state_r.to_ctl))
        else $error("timer one control reset by other reset");
    AST_CAUSE_POR: assert property (por_evt |=> (state_r.cause & ~RC_POR_Q) == RC_POR)
        else $error("power-on cause wrong");
    AST_CAUSE_RST: assert property (rst_evt && !por_evt |=>
        state_r.cause == (RC_RST | ({4'h0, $past(cause_q)} & RC_Q) | ($past(state_r.cause) & RC_KEEP_RST)))
        else $error("other reset cause wrong");
    AST_PC_STEP: assert property (wake && !vec_take |=> pc == $past(pc_now) + PC_STEP)
        else $error("wake program counter wrong");
    AST_PC_RESET: assert property (any_rst |=> pc == PC_RESET)
        else $error("reset program counter wrong");
    AST_MASKS: assert property (state_r.to_ctl[6] == 1'b0 && state_r.tt_ctl[7] == 1'b0
        && state_r.alu[7:5] == 3'b000)
        else $error("unimplemented bit set");
    AST_SERIAL: assert property (any_rst |=>
        state_r.sctl1 == 8'h00 && state_r.bank == 8'h00 && state_r.wd == 8'h00)
        else $error("serial or bank not cleared");
    AST_IND_VIEW: assert property (rd_stb && addr >= A_IND_FIRST && addr <= A_IND_LAST |=> rd_data == 8'h00)
        else $error("indirect view read not zero");

    COV_INT_WAKE: cover property (wake && vec_take);
    COV_WDT_WAKE: cover property (wake_wdt_evt && !any_rst);
    COV_RST_THEN_POR: cover property (rst_evt ##[1:40] por_evt);
    COV_BIT6_GATED: cover property (wr_stb && addr == A_LAT && !osc_io_mode);
endmodule : reset_init

//--- dv/reset_init_tb.sv
/*
 * self-checking bench for reset_init: reset values, write masks, reset classes,
 * wake-up handling of program counter, stack and flags, and port bit 6 gating.
 * assumes the reset_init_pkg index constants and a 50 MHz clk_sys.
 */
module reset_init_tb
    import reset_init_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;

    logic clk_sys, reset_n, wr_stb, rd_stb, por_evt, rst_evt, wake_wdt_evt, wake_int_evt;
    logic int_high_prio, hi_en, lo_en, osc_io_mode;
    logic [7:0] addr, wr_data, rd_data, wake_int_ctl_set, wake_flag_set, first_port_pins, can_status_in;
    logic [7:0] first_port_latch, first_port_direction, stack_top_high, stack_top_low, v;
    logic [3:0] cause_q;
    logic [20:0] pc_now, pc;
    logic [4:0] stack_top_upper, return_stack_pointer;
    int n_mismatch = 0;
    int n_tests = 0;

    // ----------------------------------------
    // ordinary cases: write a value, read back what the implemented bits keep
    // ----------------------------------------
    row_t rows [14] = '{'{A_TZ_CTL, 8'h5A, 8'h5A}, '{A_TO_CTL, 8'hFF, 8'hBF}, '{A_TT_CTL, 8'hFF, 8'h7F},
        '{A_LVD, 8'hFF, 8'h3F}, '{A_OSC, 8'hFF, 8'h01}, '{A_WD, 8'hFF, 8'h01}, '{A_P1_UP, 8'hFF, 8'h0F},
        '{A_BANK, 8'hFF, 8'h0F}, '{A_ALU, 8'hFF, 8'h1F}, '{A_SSTAT, 8'hA5, 8'hA5}, '{A_P1_LO, 8'h77, 8'h77},
        '{A_TT_PER, 8'h12, 8'h12}, '{A_IND_FIRST, 8'h55, 8'h00}, '{8'h40, 8'h55, 8'h00}};
    row_t rv [8] = '{'{A_TZ_CTL, 8'h00, 8'hFF}, '{A_TT_PER, 8'h00, 8'hFF}, '{A_LVD, 8'h00, 8'h05},
        '{A_CAUSE, 8'h00, 8'h1C}, '{A_TT_CTL, 8'h00, 8'h00}, '{A_SADDR, 8'h00, 8'h00}, '{A_P2_UP, 8'h00, 8'h00},
        '{A_OSC, 8'h00, 8'h00}};

    reset_init dut (.clk_sys(clk_sys), .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rd_data(rd_data), .por_evt(por_evt), .rst_evt(rst_evt), .wake_wdt_evt(wake_wdt_evt),
        .wake_int_evt(wake_int_evt), .int_high_prio(int_high_prio), .high_priority_global_int_enable(hi_en),
        .low_priority_global_int_enable(lo_en), .cause_q(cause_q), .wake_int_ctl_set(wake_int_ctl_set),
        .wake_flag_set(wake_flag_set), .pc_now(pc_now), .pc(pc), .stack_top_upper(stack_top_upper),
        .stack_top_high(stack_top_high), .stack_top_low(stack_top_low),
        .return_stack_pointer(return_stack_pointer), .osc_io_mode(osc_io_mode),
        .first_port_pins(first_port_pins), .can_status_in(can_status_in),
        .first_port_latch(first_port_latch), .first_port_direction(first_port_direction));

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
            n_mismatch++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), rd_data, e);
    endtask : rchk

    // k: 0 power-on, 1 other reset, 2 watchdog wake, 3 interrupt wake
    task automatic ev(input int k, input logic h, input logic l, input logic p);
        @(posedge clk_sys);
        hi_en <= h;
        lo_en <= l;
        int_high_prio <= p;
        case (k)
            0: por_evt <= 1'b1;
            1: rst_evt <= 1'b1;
            2: wake_wdt_evt <= 1'b1;
            default: wake_int_evt <= 1'b1;
        endcase
        @(posedge clk_sys);
        {por_evt, rst_evt, wake_wdt_evt, wake_int_evt} <= 4'h0;
        #1;
    endtask : ev

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    initial
    begin
        repeat (5000) @(posedge clk_sys);
        n_mismatch++;
        test_done;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {reset_n, wr_stb, rd_stb, por_evt, rst_evt, wake_wdt_evt, wake_int_evt} = '0;
        {int_high_prio, hi_en, lo_en, addr, wr_data} = '0;
        osc_io_mode = 1'b1;
        cause_q = 4'h6;
        wake_int_ctl_set = 8'h80;
        wake_flag_set = 8'h04;
        first_port_pins = 8'hFF;
        can_status_in = 8'h3C;
        pc_now = 21'h012345;
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        foreach (rv[i]) rchk(rv[i].a, rv[i].e);
        for (int n = A_CAN; n <= A_CAN_LAST; n++) rchk(n[7:0], 8'h3C);
        @(posedge clk_sys);
        #1;
        chk("rd_data idle", rd_data, 8'h00);
        $display("test reset values done");
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rchk(rows[i].a, rows[i].e);
        end
        $display("test write masks done");
        // watchdog wake resumes in line, reloads the period and updates the cause bits
        ev(2, 1'b0, 1'b0, 1'b0);
        chk("pc wdt", pc, 21'h012347);
        chk("sp wdt", return_stack_pointer, 5'h00);
        rchk(A_TT_PER, 8'hFF);
        rchk(A_TZ_CTL, 8'h5A);
        rchk(A_TO_CTL, 8'hBF);
        rchk(A_LVD, 8'h3F);
        rchk(A_CAUSE, 8'h14);
        $display("test watchdog wake done");
        wr(A_IFLAG, 8'h01);
        ev(3, 1'b1, 1'b0, 1'b1);
        chk("pc high", pc, 21'h000008);
        chk("tos", {stack_top_upper, stack_top_high, stack_top_low}, 21'h012345);
        chk("sp high", return_stack_pointer, 5'h01);
        rchk(A_IFLAG, 8'h05);
        rchk(A_INTC, 8'h80);
        ev(3, 1'b0, 1'b1, 1'b0);
        chk("pc low", pc, 21'h000018);
        chk("sp low", return_stack_pointer, 5'h02);
        ev(3, 1'b0, 1'b0, 1'b1);
        chk("pc no enable", pc, 21'h012347);
        chk("sp no enable", return_stack_pointer, 5'h02);
        $display("test interrupt wake done");
        ev(1, 1'b0, 1'b0, 1'b0);
        chk("pc reset", pc, 21'h000000);
        rchk(A_TZ_CTL, 8'hFF);
        rchk(A_TO_CTL, 8'hBF);
        rchk(A_P1_LO, 8'h77);
        rchk(A_ALU, 8'h1F);
        rchk(A_SSTAT, 8'h00);
        rchk(A_TT_CTL, 8'h00);
        rchk(A_BANK, 8'h00);
        rchk(A_WD, 8'h00);
        rchk(A_OSC, 8'h00);
        rchk(A_LVD, 8'h05);
        rchk(A_CAUSE, 8'h14);
        ev(0, 1'b0, 1'b0, 1'b0);
        rchk(A_TO_CTL, 8'h00);
        rchk(A_CAUSE, 8'h1E);
        $display("test reset classes done");
        // bit 6 of the port exists only in the two io oscillator modes
        @(posedge clk_sys);
        osc_io_mode <= 1'b0;
        wr(A_LAT, 8'hFF);
        wr(A_DIR, 8'hFF);
        rchk(A_LAT, 8'hBF);
        rchk(A_PINS, 8'hBF);
        chk("latch port", first_port_latch, 8'hBF);
        chk("dir port", first_port_direction, 8'hBF);
        @(posedge clk_sys);
        osc_io_mode <= 1'b1;
        wr(A_LAT, 8'hFF);
        rchk(A_LAT, 8'hFF);
        rchk(A_PINS, 8'hFF);
        $display("test port bit 6 done");
        // move pc and period off their reset values so the mid-run reset is seen to act
        ev(2, 1'b0, 1'b0, 1'b0);
        chk("pc before reset", pc, 21'h012347);
        wr(A_TT_PER, 8'h12);
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        #1;
        chk("pc mid reset", pc, 21'h000000);
        rchk(A_CAUSE, 8'h1C);
        rchk(A_TT_PER, 8'hFF);
        $display("test mid-run reset done");
        test_done;
    end
endmodule : reset_init_tb
